// file: rtl/acs_pkg.sv
package acs_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [2:0] ADDR_ADC_CONTROL  = 3'h0;
  localparam logic [2:0] ADDR_ADC_CONFIG   = 3'h1;
  localparam logic [2:0] ADDR_DCDC_CONFIG  = 3'h2;
  localparam logic [2:0] ADDR_DCDC_CONTROL = 3'h3;
  localparam logic [2:0] ADDR_RESULT_HIGH  = 3'h4;
  localparam logic [2:0] ADDR_RESULT_LOW   = 3'h5;

  // Field positions
  localparam int CTL_SRC_LSB   = 0;
  localparam int CTL_BUSY_BIT  = 4;
  localparam int CTL_DONE_BIT  = 5;
  localparam int CTL_IRQEN_BIT = 7;
  localparam int CFG_DIV_LSB   = 0;
  localparam int CFG_BURST_BIT = 6;
  localparam int DCF_INV_BIT   = 0;
  localparam int DCN_SYNC_BIT  = 0;
  localparam int DCN_ONE_BIT   = 1;

  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 100;
  localparam int MAX_RATE_KSPS   = 300;
  localparam int SYNC_RATE_KSPS  = 170;
  localparam int SYNC_HOLD_NS    = 625;
  localparam int MIN_CONV_CYC    = (1_000_000 + MAX_RATE_KSPS * CLK_PERIOD_NS - 1)
                                   / (MAX_RATE_KSPS * CLK_PERIOD_NS);
  localparam int SYNC_CONV_CYC   = (1_000_000 + SYNC_RATE_KSPS * CLK_PERIOD_NS - 1)
                                   / (SYNC_RATE_KSPS * CLK_PERIOD_NS);
  localparam int SYNC_HOLD_RAW   = SYNC_HOLD_NS / CLK_PERIOD_NS;
  localparam int SYNC_HOLD_CYC   = (SYNC_HOLD_RAW < 1) ? 1 : SYNC_HOLD_RAW;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SRC_SOFTWARE = 3'b000,
    SRC_TIMER0   = 3'b001,
    SRC_TIMER2   = 3'b010,
    SRC_TIMER3   = 3'b011,
    SRC_EXT_PIN  = 3'b100
  } acs_src_t;

  typedef enum logic [1:0] {
    ST_IDLE      = 2'b00,
    ST_SYNC_WAIT = 2'b01,
    ST_CONVERT   = 2'b10
  } acs_state_t;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wrData;
    logic       wrStb;
    logic       rdStb;
  } acs_bus_t;

  typedef struct packed {
    logic t0Ovf;
    logic t2LowOvf;
    logic t2HighOvf;
    logic t2Mode16;
    logic t3LowOvf;
    logic t3HighOvf;
    logic t3Mode16;
    logic extConvStart;
  } acs_trig_t;

  typedef struct packed {
    acs_state_t state;
    logic [4:0] divCnt;
    logic [4:0] tickCnt;
    logic [6:0] periodCnt;
    logic [2:0] holdCnt;
    logic       extPrev;
    logic       lpPrev;
    logic       dcPrev;
    logic [2:0] srcSel;
    logic       irqEn;
    logic       done;
    logic [4:0] clkDiv;
    logic       burst;
    logic       clkInv;
    logic       syncEn;
    logic       oneCell;
    logic [7:0] resHi;
    logic [7:0] resLo;
    logic [7:0] rdData;
    logic       tick;
    logic       irq;
  } acs_regs_t;

endpackage : acs_pkg

// file: rtl/acs_adc_conversion_start_control.sv
`timescale 1ns/1ps
module acs_adc_conversion_start_control #(
  parameter int DATA_W     = 10,
  parameter int CONV_TICKS = 12,
  parameter bit LATE_REV   = 1'b1
) (
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rst,
  // Register port
  input  wire acs_pkg::acs_bus_t bus,
  output logic [7:0]             rdData,
  // Trigger partners
  input  wire acs_pkg::acs_trig_t trig,
  // Clock sources
  input  wire logic              lpOscClk,
  input  wire logic              dcdcClk,
  input  wire logic              dcdcSync,
  // Analog converter
  input  wire logic [DATA_W-1:0] adcData,
  output logic                   convClkTick,
  // Status
  output logic                   convBusy,
  output logic                   convDoneFlag,
  output logic                   convIrqReq
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic riseEdge(input logic cur, input logic prev);
    riseEdge = cur & ~prev;
  endfunction : riseEdge

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  acs_pkg::acs_regs_t r_ff;
  acs_pkg::acs_regs_t nxt_r;

  logic               syncMode;
  logic               dcClkMode;
  logic               srcEv;
  logic               tickNow;
  logic               trigNow;
  logic               swStart;
  logic               wrCtl;
  logic [15:0]        resWide;
  logic [6:0]         minPeriod;

  always_comb begin
    nxt_r     = r_ff;
    syncMode  = r_ff.syncEn & r_ff.oneCell;
    dcClkMode = syncMode & LATE_REV;
    srcEv     = 1'b1;
    tickNow   = 1'b0;
    trigNow   = 1'b0;
    swStart   = 1'b0;
    wrCtl     = bus.wrStb && (bus.addr == acs_pkg::ADDR_ADC_CONTROL);
    resWide   = 16'h0000;
    resWide[DATA_W-1:0] = adcData;
    minPeriod = dcClkMode ? 7'(acs_pkg::SYNC_CONV_CYC)
                          : 7'(acs_pkg::MIN_CONV_CYC);

    // ------------------------------------------------------------
    // Edge history of sampled inputs
    // ------------------------------------------------------------
    nxt_r.extPrev = trig.extConvStart;
    nxt_r.lpPrev  = lpOscClk;
    nxt_r.dcPrev  = dcdcClk;

    // ------------------------------------------------------------
    // Conversion clock source and divider
    // ------------------------------------------------------------
    if (dcClkMode) begin
      // Falling edge when inverted
      srcEv = r_ff.clkInv ? riseEdge(~dcdcClk, ~r_ff.dcPrev)
                          : riseEdge(dcdcClk, r_ff.dcPrev);
    end else if (r_ff.burst) begin
      srcEv = riseEdge(lpOscClk, r_ff.lpPrev);
    end
    // Divider idles outside conversion so each one starts phase aligned
    if (r_ff.state == acs_pkg::ST_CONVERT && srcEv) begin
      if (r_ff.divCnt >= r_ff.clkDiv) begin
        nxt_r.divCnt = 5'h00;
        tickNow      = 1'b1;
      end else begin
        nxt_r.divCnt = r_ff.divCnt + 5'h01;
      end
    end
    nxt_r.tick = tickNow;

    // ------------------------------------------------------------
    // Start source selection
    // ------------------------------------------------------------
    swStart = wrCtl && bus.wrData[acs_pkg::CTL_BUSY_BIT];
    unique case (r_ff.srcSel)
      acs_pkg::SRC_SOFTWARE: trigNow = swStart;
      acs_pkg::SRC_TIMER0:   trigNow = trig.t0Ovf;
      acs_pkg::SRC_TIMER2:   trigNow = trig.t2Mode16 ? trig.t2HighOvf
                                                     : trig.t2LowOvf;
      acs_pkg::SRC_TIMER3:   trigNow = trig.t3Mode16 ? trig.t3HighOvf
                                                     : trig.t3LowOvf;
      acs_pkg::SRC_EXT_PIN:  trigNow = riseEdge(trig.extConvStart,
                                                r_ff.extPrev);
      default:               trigNow = 1'b0;
    endcase

    // ------------------------------------------------------------
    // Conversion sequencer
    // ------------------------------------------------------------
    unique case (r_ff.state)
      acs_pkg::ST_IDLE: begin
        if (trigNow) begin
          nxt_r.divCnt    = 5'h00;
          nxt_r.tickCnt   = 5'h00;
          nxt_r.periodCnt = minPeriod;
          nxt_r.holdCnt   = 3'(acs_pkg::SYNC_HOLD_CYC);
          nxt_r.state     = syncMode ? acs_pkg::ST_SYNC_WAIT
                                     : acs_pkg::ST_CONVERT;
        end
      end
      acs_pkg::ST_SYNC_WAIT: begin
        // Give up after one slow dc-dc period so a lost sync cannot hang it
        if (dcdcSync || r_ff.holdCnt <= 3'h1) begin
          nxt_r.state = acs_pkg::ST_CONVERT;
        end else begin
          nxt_r.holdCnt = r_ff.holdCnt - 3'h1;
        end
      end
      acs_pkg::ST_CONVERT: begin
        if (r_ff.periodCnt != 7'h00) begin
          nxt_r.periodCnt = r_ff.periodCnt - 7'h01;
        end
        if (tickNow && r_ff.tickCnt != 5'(CONV_TICKS)) begin
          nxt_r.tickCnt = r_ff.tickCnt + 5'h01;
        end
        if (r_ff.tickCnt == 5'(CONV_TICKS) && r_ff.periodCnt <= 7'h01) begin
          nxt_r.state  = acs_pkg::ST_IDLE;
          nxt_r.resHi  = resWide[15:8];
          nxt_r.resLo  = resWide[7:0];
          nxt_r.divCnt = 5'h00;
        end
      end
      default: nxt_r.state = acs_pkg::ST_IDLE;
    endcase

    // ------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------
    if (wrCtl) begin
      nxt_r.srcSel = bus.wrData[acs_pkg::CTL_SRC_LSB +: 3];
      nxt_r.irqEn  = bus.wrData[acs_pkg::CTL_IRQEN_BIT];
      if (!bus.wrData[acs_pkg::CTL_DONE_BIT]) begin
        nxt_r.done = 1'b0;
      end
    end
    if (bus.wrStb && bus.addr == acs_pkg::ADDR_ADC_CONFIG) begin
      nxt_r.clkDiv = bus.wrData[acs_pkg::CFG_DIV_LSB +: 5];
      nxt_r.burst  = bus.wrData[acs_pkg::CFG_BURST_BIT];
    end
    if (bus.wrStb && bus.addr == acs_pkg::ADDR_DCDC_CONFIG) begin
      nxt_r.clkInv = bus.wrData[acs_pkg::DCF_INV_BIT];
    end
    if (bus.wrStb && bus.addr == acs_pkg::ADDR_DCDC_CONTROL) begin
      nxt_r.syncEn  = bus.wrData[acs_pkg::DCN_SYNC_BIT];
      nxt_r.oneCell = bus.wrData[acs_pkg::DCN_ONE_BIT];
    end

    // Busy falling edge sets done; set beats a same-cycle clear
    if (r_ff.state == acs_pkg::ST_CONVERT && nxt_r.state == acs_pkg::ST_IDLE) begin
      nxt_r.done = 1'b1;
    end
    nxt_r.irq = nxt_r.done & nxt_r.irqEn;

    // ------------------------------------------------------------
    // Register reads, data in the cycle after the strobe
    // ------------------------------------------------------------
    nxt_r.rdData = acs_pkg::RST_BYTE;
    if (bus.rdStb) begin
      unique case (bus.addr)
        acs_pkg::ADDR_ADC_CONTROL: begin
          nxt_r.rdData[acs_pkg::CTL_SRC_LSB +: 3] = r_ff.srcSel;
          nxt_r.rdData[acs_pkg::CTL_BUSY_BIT]     =
            (r_ff.state != acs_pkg::ST_IDLE);
          nxt_r.rdData[acs_pkg::CTL_DONE_BIT]     = r_ff.done;
          nxt_r.rdData[acs_pkg::CTL_IRQEN_BIT]    = r_ff.irqEn;
        end
        acs_pkg::ADDR_ADC_CONFIG: begin
          nxt_r.rdData[acs_pkg::CFG_DIV_LSB +: 5] = r_ff.clkDiv;
          nxt_r.rdData[acs_pkg::CFG_BURST_BIT]    = r_ff.burst;
        end
        acs_pkg::ADDR_DCDC_CONFIG: begin
          nxt_r.rdData[acs_pkg::DCF_INV_BIT] = r_ff.clkInv;
        end
        acs_pkg::ADDR_DCDC_CONTROL: begin
          nxt_r.rdData[acs_pkg::DCN_SYNC_BIT] = r_ff.syncEn;
          nxt_r.rdData[acs_pkg::DCN_ONE_BIT]  = r_ff.oneCell;
        end
        acs_pkg::ADDR_RESULT_HIGH: nxt_r.rdData = r_ff.resHi;
        acs_pkg::ADDR_RESULT_LOW:  nxt_r.rdData = r_ff.resLo;
        default:                   nxt_r.rdData = acs_pkg::RST_BYTE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      r_ff <= '0;
    end else begin
      r_ff <= nxt_r;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign rdData       = r_ff.rdData;
  assign convClkTick  = r_ff.tick;
  assign convBusy     = (r_ff.state != acs_pkg::ST_IDLE);
  assign convDoneFlag = r_ff.done;
  assign convIrqReq   = r_ff.irq;

endmodule : acs_adc_conversion_start_control

// file: tb/acs_conv_start_sva.sv
`timescale 1ns/1ps
module acs_conv_start_sva (
  // Clock and reset
  input wire logic               ref_clk,
  input wire logic               rst,
  // Watched ports
  input wire acs_pkg::acs_bus_t  bus,
  input wire acs_pkg::acs_trig_t trig,
  input wire logic               convClkTick,
  input wire logic               convBusy,
  input wire logic               convDoneFlag,
  input wire logic               convIrqReq
);
  // ----------------------------------------
  // Shadow of software settings
  // ----------------------------------------
  logic [2:0] srcSh_ff;
  logic       irqSh_ff;
  logic       extPrev_ff;
  logic [7:0] busyCnt_ff;
  logic       ctlWr;
  logic       tgo;
  assign ctlWr = bus.wrStb && bus.addr == acs_pkg::ADDR_ADC_CONTROL;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      srcSh_ff   <= 3'h0;
      irqSh_ff   <= 1'b0;
      extPrev_ff <= 1'b0;
      busyCnt_ff <= 8'h00;
    end else begin
      if (ctlWr) begin
        srcSh_ff <= bus.wrData[2:0];
        irqSh_ff <= bus.wrData[7];
      end
      extPrev_ff <= trig.extConvStart;
      busyCnt_ff <= convBusy ? busyCnt_ff + 8'h01 : 8'h00;
    end
  end
  always_comb begin
    case (srcSh_ff)
      3'h1: tgo = trig.t0Ovf;
      3'h2: tgo = trig.t2Mode16 ? trig.t2HighOvf : trig.t2LowOvf;
      3'h3: tgo = trig.t3Mode16 ? trig.t3HighOvf : trig.t3LowOvf;
      3'h4: tgo = trig.extConvStart && !extPrev_ff;
      default: tgo = 1'b0;
    endcase
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence s_swStart;
    ctlWr && bus.wrData[4] && bus.wrData[2:0] == 3'h0 && srcSh_ff == 3'h0 && !convBusy;
  endsequence
  sequence s_finish;
    $fell(convBusy);
  endsequence
  a_sw_start: assert property (s_swStart |=> convBusy)
    else $error("software start missed");
  a_trig_select: assert property (
    !convBusy && !bus.wrStb && srcSh_ff != 3'h0 |=> convBusy == $past(tgo))
    else $error("start source mismatch");
  a_busy_through: assert property ($rose(convBusy) |-> convBusy[*8])
    else $error("busy dropped early");
  a_min_length: assert property (
    s_finish |-> busyCnt_ff >= 8'(acs_pkg::MIN_CONV_CYC))
    else $error("conversion too short");
  a_done_on_fall: assert property (s_finish |-> convDoneFlag)
    else $error("done not set at busy fall");
  a_done_sticky: assert property (
    convDoneFlag && !(ctlWr && !bus.wrData[5]) |=> convDoneFlag)
    else $error("done lost");
  a_done_clear: assert property (ctlWr && !bus.wrData[5] && !convBusy |=> !convDoneFlag)
    else $error("done not cleared");
  // Request is registered beside the flag, so both move on one edge
  a_irq_follow: assert property (
    1'b1 |-> convIrqReq == (convDoneFlag && irqSh_ff))
    else $error("irq request mismatch");
  a_tick_busy: assert property (convClkTick |-> $past(convBusy))
    else $error("conversion tick outside conversion");
endmodule : acs_conv_start_sva

bind acs_adc_conversion_start_control acs_conv_start_sva u_sva (
  .ref_clk(ref_clk), .rst(rst), .bus(bus), .trig(trig), .convClkTick(convClkTick),
  .convBusy(convBusy),
  .convDoneFlag(convDoneFlag), .convIrqReq(convIrqReq)
);

// file: tb/acs_partner_model.sv
`timescale 1ns/1ps
module acs_partner_model (
  // Clock and reset
  input  wire logic         ref_clk,
  input  wire logic         rst,
  // Bench controls
  input  wire logic         pinLvl,
  input  wire logic         mode16,
  // Far side
  output acs_pkg::acs_trig_t trig,
  output logic              lpOscClk,
  output logic              dcdcClk,
  output logic              dcdcSync
);
  // ----------------------------------------
  // Timers and clocks
  // ----------------------------------------
  logic [7:0] cnt_ff;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cnt_ff <= 8'h00;
    end else begin
      cnt_ff <= cnt_ff + 8'h01;
    end
  end
  // Low and high overflows never coincide, so a wrong pick shows
  assign trig.t0Ovf        = cnt_ff[3:0] == 4'hF;
  assign trig.t2LowOvf     = cnt_ff[2:0] == 3'h3;
  assign trig.t2HighOvf    = cnt_ff == 8'hB1;
  assign trig.t2Mode16     = mode16;
  assign trig.t3LowOvf     = cnt_ff[2:0] == 3'h5;
  assign trig.t3HighOvf    = cnt_ff == 8'h62;
  assign trig.t3Mode16     = mode16;
  assign trig.extConvStart = pinLvl;
  assign lpOscClk          = cnt_ff[2];
  // Dc-dc clock 2.5 MHz, inside its 1.6 to 3.2 MHz range
  assign dcdcClk           = cnt_ff[1];
  assign dcdcSync          = cnt_ff[1:0] == 2'h1;
endmodule : acs_partner_model

// file: tb/acs_adc_conversion_start_control_tb.sv
`timescale 1ns/1ps
module acs_adc_conversion_start_control_tb;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  localparam logic [2:0] CTL = acs_pkg::ADDR_ADC_CONTROL;
  logic               ref_clk = 1'b0;
  logic               rst = 1'b1;
  acs_pkg::acs_bus_t  bus = '0;
  acs_pkg::acs_trig_t trig;
  logic               pinLvl = 1'b0;
  logic               mode16 = 1'b0;
  logic [9:0]         adcData = 10'h2A5;
  logic [7:0]         rdData;
  logic               lpOscClk, dcdcClk, dcdcSync, convClkTick;
  logic               convBusy, convDoneFlag, convIrqReq;
  int                 errTotal = 0;
  int                 nChecks = 0;
  int                 tickSeen = 0;
  always #50 ref_clk = ~ref_clk;
  acs_adc_conversion_start_control dut (
    .ref_clk(ref_clk), .rst(rst), .bus(bus), .rdData(rdData), .trig(trig),
    .lpOscClk(lpOscClk), .dcdcClk(dcdcClk), .dcdcSync(dcdcSync), .adcData(adcData),
    .convClkTick(convClkTick), .convBusy(convBusy), .convDoneFlag(convDoneFlag),
    .convIrqReq(convIrqReq));
  acs_partner_model u_far (
    .ref_clk(ref_clk), .rst(rst), .pinLvl(pinLvl), .mode16(mode16), .trig(trig),
    .lpOscClk(lpOscClk), .dcdcClk(dcdcClk), .dcdcSync(dcdcSync));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic final_report;
    $display("checks %0d mismatches %0d", nChecks, errTotal);
    if (errTotal == 0 && nChecks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : final_report
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    nChecks++;
    if (g !== e) begin
      errTotal++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    bus.addr <= a;
    bus.wrData <= d;
    bus.wrStb <= 1'b1;
    @(posedge ref_clk);
    bus.wrStb <= 1'b0;
  endtask : wr
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    bus.addr <= a;
    bus.rdStb <= 1'b1;
    @(posedge ref_clk);
    bus.rdStb <= 1'b0;
    @(negedge ref_clk);
    d = rdData;
  endtask : rd
  // Polls the done flag, counting busy cycles and conversion ticks on the way
  task automatic waitConv(output int len);
    int k;
    len = 0;
    tickSeen = 0;
    for (k = 0; k < 2000 && convDoneFlag !== 1'b1; k++) begin
      @(negedge ref_clk);
      len += int'(convBusy === 1'b1);
      tickSeen += int'(convClkTick === 1'b1);
    end
    if (k >= 2000) begin
      errTotal++;
      final_report();
    end
  endtask : waitConv
  task automatic settle;
    wr(CTL, 8'h00);
    repeat (120) @(negedge ref_clk);
    wr(CTL, 8'h00);
  endtask : settle
  task automatic t_sw;
    int len;
    logic [7:0] d;
    wr(CTL, 8'h10);
    rd(CTL, d);
    chk("busyBit", 8'h10, d & 8'h10);
    wr(CTL, 8'h10);
    waitConv(len);
    chk("noRestart", 8'h01, 8'(len + 4 <= acs_pkg::MIN_CONV_CYC + 3));
    rd(acs_pkg::ADDR_RESULT_HIGH, d);
    chk("resHigh", 8'h02, d);
    rd(acs_pkg::ADDR_RESULT_LOW, d);
    chk("resLow", 8'hA5, d);
    wr(CTL, 8'hA0);
    rd(CTL, d);
    chk("ctlRead", 8'hA0, d);
    chk("irqOn", 8'h01, {7'h00, convIrqReq});
    wr(CTL, 8'h80);
    rd(CTL, d);
    chk("ctlClr", 8'h80, d);
    chk("irqOff", 8'h00, {7'h00, convIrqReq});
    settle();
  endtask : t_sw
  task automatic t_src;
    int len;
    for (int s = 1; s <= 5; s++) begin
      mode16 <= s[0];
      wr(CTL, 8'(s));
      if (s == 4) begin
        // Pin pulse for three cycles, its rising edge starts the conversion
        pinLvl <= 1'b1;
        repeat (3) @(posedge ref_clk);
        pinLvl <= 1'b0;
      end
      if (s == 5) begin
        repeat (300) @(negedge ref_clk);
        chk("badSrc", 8'h00, {7'h00, convBusy});
      end else begin
        waitConv(len);
        chk("srcDone", 8'h01, {7'h00, convDoneFlag});
      end
      // Back to software source, or later busy-bit starts are refused
      settle();
    end
  endtask : t_src
  task automatic t_cfg;
    int len;
    logic [7:0] cfg[4] = '{8'h00, 8'h03, 8'h40, 8'h00};
    int mins[4] = '{acs_pkg::MIN_CONV_CYC, 44, 88, acs_pkg::SYNC_CONV_CYC};
    for (int i = 0; i < 4; i++) begin
      wr(acs_pkg::ADDR_ADC_CONFIG, cfg[i]);
      wr(acs_pkg::ADDR_DCDC_CONFIG, 8'(i == 3));
      wr(acs_pkg::ADDR_DCDC_CONTROL, (i == 3) ? 8'h03 : 8'h00);
      wr(CTL, 8'h10);
      waitConv(len);
      chk("lenMin", 8'h01, 8'(len >= mins[i]));
      if (i == 1) begin
        // Twelve ticks at divide by four outlast the rate floor
        chk("tickCnt", 8'h0C, 8'(tickSeen));
      end
      if (i == 3) begin
        chk("holdMax", 8'h01, 8'(len <= mins[i] + acs_pkg::SYNC_HOLD_CYC + 2));
      end
      settle();
    end
  endtask : t_cfg
  initial begin
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    t_sw();
    $display("test software start end");
    t_src();
    $display("test sources end");
    t_cfg();
    $display("test clock config end");
    final_report();
  end
endmodule : acs_adc_conversion_start_control_tb
